/* File: stop_lvs_defines.vh */
// Constants for the stop exit and low voltage supervisor block
`ifndef STOP_LVS_DEFINES_VH
`define STOP_LVS_DEFINES_VH
`define ADDR_CONFIG_ONE 4'h0
`define ADDR_LV_STATUS 4'h4
`define ADDR_WAKE_INFO 4'h8
`define ADDR_MODE_CTRL 4'hc
`define BIT_SHORT_REC 0
`define BIT_SUP_PWR_OFF 1
`define BIT_SUP_RST_OFF 2
`define BIT_SUP_STOP_EN 3
`define BIT_TRIP_RANGE 4
`define BIT_LOW_FLAG 7
`define BIT_STOP_REQ 0
`define BIT_WAIT_REQ 1
`define BIT_TB_IRQ_EN 2
`define CONFIG_ONE_RST 5'h00
`define VEC_RESET 16'hfffe
`define VEC_EXT_IRQ 16'hfffa
`define VEC_KEYPAD 16'hffe0
`define VEC_TIMEBASE 16'hffdc
`define REC_FULL 12'hfff
`define REC_SHORT 12'h01f
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: stop_exit_low_voltage_reset.v */
// Stop-mode exit sequencer and low voltage supervisor with AXI4-Lite registers
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "stop_lvs_defines.vh"

// Operation
// - External reset pin low in stop restarts clocks, resets, vectors to FFFE.
// - Falling edge on interrupt or keypad pin wakes from stop, own vector.
// - Supply under falling level with supervisor on resets, ends stop, vector FFFE.
// - Timebase rollover with interrupt enabled wakes from stop via FFDC vector.
// - Twelve-bit recovery counter holds clocks off 4096 oscillator cycles after wake.
// - Short-recovery bit set shortens recovery to 32 oscillator cycles.
// - Supervisor comes out of reset enabled and monitoring.
// - Supervisor monitors only while its power-off bit is cleared.
// - Supervisor resets on low supply only when reset-off cleared and monitoring.
// - Supervisor reset works in stop only when its stop-enable bit is set.
// - Trip-range bit one selects 5-V thresholds, zero selects 3-V.
// - Power-on reset returns trip range to 3-V setting.
// - Selecting 5-V while supply under 5-V rising level enters reset at once.
// - Low-voltage reset holds until comparator reports supply above rising level.
// - Low-voltage reset also drives the external reset pin low.
// - Status flag sets below falling, clears above rising, holds between, resets clear.
// - Supervisor raises no interrupts; outputs are reset and status flag.
// - Enabled supervisor stays active in wait and its reset ends wait.
module stop_exit_low_voltage_reset #(
  parameter REC_FULL_CNT = 4096,
  parameter REC_SHORT_CNT = 32
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // AXI4-Lite write channels
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pins and comparator (asynchronous)
  input wire ext_reset_pin_in,
  input wire ext_irq_pin,
  input wire [7:0] keypad_pins,
  input wire below_falling_threshold,
  input wire above_rising_threshold,
  input wire por_event,
  // Timebase event from same domain
  input wire timebase_rollover,
  // Outputs
  output reg ext_reset_pin_out,
  output reg ext_reset_pin_oe,
  output reg device_reset,
  output reg sys_clk_enable,
  output reg stop_active,
  output reg wait_active,
  output reg [15:0] wake_vector,
  output reg vector_load
);

  localparam ST_RUN = 2'h0;
  localparam ST_STOP = 2'h1;
  localparam ST_REC = 2'h2;

  // Two-flop synchronisers for every asynchronous input
  reg [12:0] sync1_r;
  reg [12:0] sync2_r;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      // Idle pin levels, so release of reset shows no edge and no outside reset
      sync1_r <= 13'h03ff;
      sync2_r <= 13'h03ff;
    end else begin
      sync1_r <= {por_event, above_rising_threshold, below_falling_threshold,
                  keypad_pins, ext_irq_pin, ext_reset_pin_in};
      sync2_r <= sync1_r;
    end
  end
  wire rst_pin_s = sync2_r[0];
  wire irq_s = sync2_r[1];
  wire [7:0] kp_s = sync2_r[9:2];
  wire below_s = sync2_r[10];
  wire above_s = sync2_r[11];
  wire por_s = sync2_r[12];

  reg irq_d_r;
  reg [7:0] kp_d_r;
  reg [4:0] cfg_r;
  reg [2:0] mode_r;
  reg low_flag_r;
  reg lv_hold_r;
  reg [1:0] state_r;
  reg [11:0] rec_cnt_r;
  reg [1:0] wake_src_r;
  reg [2:0] oe_echo_r;
  reg range_prev_r;
  reg [2:0] range_rise_r;
  reg lv_hold_nxt;
  reg low_flag_nxt;

  wire short_recovery_sel = cfg_r[`BIT_SHORT_REC];
  wire supervisor_power_off = cfg_r[`BIT_SUP_PWR_OFF];
  wire supervisor_reset_off = cfg_r[`BIT_SUP_RST_OFF];
  wire supervisor_stop_enable = cfg_r[`BIT_SUP_STOP_EN];
  wire trip_range_sel = cfg_r[`BIT_TRIP_RANGE];

  // Comparator inputs are assumed to follow the threshold set picked by trip range
  wire sup_active = !supervisor_power_off &&
                    (state_r == ST_RUN || supervisor_stop_enable);
  // A newly raised trip range is checked against the rising level once it has settled
  wire range_check = range_rise_r[2];
  wire lv_trip = sup_active && !supervisor_reset_off &&
                 (below_s || (range_check && !above_s));
  wire lv_reset = lv_trip || lv_hold_r;
  wire irq_fall = irq_d_r && !irq_s;
  wire kp_fall = |(kp_d_r & ~kp_s);
  wire tb_wake = timebase_rollover && mode_r[`BIT_TB_IRQ_EN];
  // Our own drive echoes back through the synchroniser for a while after it stops
  wire ext_rst = !rst_pin_s && !ext_reset_pin_oe && (oe_echo_r == 3'h0);

  // The core clock stands in for the oscillator clock of the recovery count
  // Terminal count chosen by short recovery bit
  wire [11:0] rec_term = short_recovery_sel ? REC_SHORT_CNT[11:0] - 12'h001 :
                         REC_FULL_CNT[11:0] - 12'h001;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      // Start at the idle high level of the pins
      irq_d_r <= 1'b1;
      kp_d_r <= 8'hff;
    end else begin
      irq_d_r <= irq_s;
      kp_d_r <= kp_s;
    end
  end

  // Supervisor: hold with hysteresis and status flag
  always @* begin
    lv_hold_nxt = lv_hold_r;
    low_flag_nxt = low_flag_r;
    if (lv_trip)
      lv_hold_nxt = 1'b1;
    else if (above_s || supervisor_power_off || por_s)
      lv_hold_nxt = 1'b0;
    if (!supervisor_power_off && below_s)
      low_flag_nxt = 1'b1;
    else if (above_s)
      low_flag_nxt = 1'b0;
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      lv_hold_r <= 1'b0;
      low_flag_r <= 1'b0;
    end else begin
      lv_hold_r <= lv_hold_nxt;
      low_flag_r <= low_flag_nxt;
    end
  end

  // Pin echo: one spare cycle beyond the synchroniser covers a slow pull-up
  always @(posedge core_clk) begin
    if (!rst_b) begin
      oe_echo_r <= 3'h0;
    end else begin
      oe_echo_r <= {oe_echo_r[1:0], ext_reset_pin_oe};
    end
  end

  // Rising edge of the trip range bit, delayed past the synchroniser
  always @(posedge core_clk) begin
    if (!rst_b) begin
      range_prev_r <= 1'b0;
      range_rise_r <= 3'h0;
    end else begin
      range_prev_r <= trip_range_sel;
      range_rise_r <= {range_rise_r[1:0], trip_range_sel && !range_prev_r};
    end
  end

  // Stop exit sequencer
  always @(posedge core_clk) begin
    if (!rst_b) begin
      state_r <= ST_RUN;
      rec_cnt_r <= 12'h000;
      wake_src_r <= 2'h0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (mode_r[`BIT_STOP_REQ] && !lv_reset && !ext_rst)
            state_r <= ST_STOP;
        end
        ST_STOP: begin
          if (ext_rst || lv_trip || irq_fall || kp_fall || tb_wake) begin
            state_r <= ST_REC;
            rec_cnt_r <= 12'h000;
            // Reset sources take priority for the vector
            if (ext_rst || lv_trip)
              wake_src_r <= 2'h0;
            else if (irq_fall)
              wake_src_r <= 2'h1;
            else if (kp_fall)
              wake_src_r <= 2'h2;
            else
              wake_src_r <= 2'h3;
          end
        end
        ST_REC: begin
          if (rec_cnt_r >= rec_term)
            state_r <= ST_RUN;
          else
            rec_cnt_r <= rec_cnt_r + 12'h001;
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  function [15:0] vec_of;
    input [1:0] src;
    begin
      case (src)
        2'h1: vec_of = `VEC_EXT_IRQ;
        2'h2: vec_of = `VEC_KEYPAD;
        2'h3: vec_of = `VEC_TIMEBASE;
        default: vec_of = `VEC_RESET;
      endcase
    end
  endfunction

  // Outputs from flops
  always @(posedge core_clk) begin
    if (!rst_b) begin
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe <= 1'b0;
      device_reset <= 1'b0;
      sys_clk_enable <= 1'b1;
      stop_active <= 1'b0;
      wait_active <= 1'b0;
      wake_vector <= `VEC_RESET;
      vector_load <= 1'b0;
    end else begin
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe <= lv_reset;
      device_reset <= lv_reset || ext_rst;
      sys_clk_enable <= (state_r == ST_RUN);
      stop_active <= (state_r == ST_STOP);
      wait_active <= mode_r[`BIT_WAIT_REQ] && !lv_reset;
      vector_load <= (state_r == ST_REC) && (rec_cnt_r >= rec_term);
      if (state_r == ST_REC)
        wake_vector <= vec_of(wake_src_r);
      else if (lv_reset || ext_rst)
        wake_vector <= `VEC_RESET;
    end
  end

  // Mapped register offsets answer OKAY; anything else gets a slave error
  function addr_mapped;
    input [3:0] addr;
    begin
      case (addr)
        `ADDR_CONFIG_ONE, `ADDR_LV_STATUS,
        `ADDR_WAKE_INFO, `ADDR_MODE_CTRL: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // AXI4-Lite slave
  reg aw_got_r;
  reg w_got_r;
  reg [3:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg w_strb0_r;
  wire aw_now = s_axi_awvalid && s_axi_awready;
  wire w_now = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_r || aw_now;
  wire w_have = w_got_r || w_now;
  wire [3:0] wa = aw_got_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd = w_got_r ? w_data_r : s_axi_wdata;
  wire ws0 = w_got_r ? w_strb0_r : s_axi_wstrb[0];
  wire do_wr = aw_have && w_have && !s_axi_bvalid;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h00000000;
      w_strb0_r <= 1'b0;
      cfg_r <= `CONFIG_ONE_RST;
      mode_r <= 3'h0;
    end else begin
      if (aw_now) begin
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_now) begin
        w_data_r <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      aw_got_r <= aw_have && !do_wr;
      w_got_r <= w_have && !do_wr;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (wa == `ADDR_CONFIG_ONE) begin
          if (ws0)
            cfg_r <= wd[4:0];
        end else if (wa == `ADDR_MODE_CTRL) begin
          if (ws0)
            mode_r <= wd[2:0];
        end else if (!addr_mapped(wa)) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // Power-on returns trip range to 3-V; stop request self-clears on wake
      if (por_s)
        cfg_r[`BIT_TRIP_RANGE] <= 1'b0;
      if (state_r == ST_REC)
        mode_r[`BIT_STOP_REQ] <= 1'b0;
      if (lv_reset && mode_r[`BIT_WAIT_REQ])
        mode_r[`BIT_WAIT_REQ] <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `ADDR_CONFIG_ONE: s_axi_rdata <= {27'h0000000, cfg_r};
          `ADDR_LV_STATUS: s_axi_rdata <= {24'h000000, low_flag_r, 7'h00};
          `ADDR_WAKE_INFO: s_axi_rdata <= {14'h0000, wake_src_r, wake_vector};
          `ADDR_MODE_CTRL: s_axi_rdata <= {27'h0000000, state_r, mode_r};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: pin_supply_model.sv */
// Model of the reset pin, wake pins and supply comparator
`timescale 1ns/10ps
`default_nettype none
module pin_supply_model (
  // Commands from the bench
  input wire logic [1:0] lvl,
  input wire logic rst_req,
  input wire logic irq_req,
  input wire logic kp_req,
  // Device side
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in,
  output logic irq_pin,
  output logic [7:0] kp_pins,
  output logic below,
  output logic above
);
  // Pulled-up pin; the device drive wins, else the outside reset
  assign pin_in = pin_oe ? pin_out : !rst_req;
  assign irq_pin = !irq_req;
  assign kp_pins = {7'h7f, !kp_req};
  // Level 0 above rising, 1 between the two levels, 2 below falling
  assign below = lvl == 2'h2;
  assign above = lvl == 2'h0;
endmodule
`default_nettype wire

/* File: stop_exit_low_voltage_reset_chk.sv */
// Port assertions for the stop exit and low voltage supervisor block
`timescale 1ns/10ps
`default_nettype none
`include "stop_lvs_defines.vh"
module lvr_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Supervisor and sequencer
  input wire logic above_rising_threshold,
  input wire logic ext_reset_pin_out,
  input wire logic ext_reset_pin_oe,
  input wire logic device_reset,
  input wire logic sys_clk_enable,
  input wire logic [15:0] wake_vector,
  input wire logic vector_load
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_oe_rst;
    ext_reset_pin_oe |-> device_reset;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin drive without reset");
  property p_pin_low;
    ext_reset_pin_oe |-> !ext_reset_pin_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  // A supply not reported above the rising level for three cycles keeps the drive
  property p_hold;
    !above_rising_threshold [*3] ##0 ext_reset_pin_oe |=> ext_reset_pin_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("reset released early");
  property p_vec_val;
    vector_load |-> wake_vector inside {`VEC_RESET, `VEC_EXT_IRQ, `VEC_KEYPAD, `VEC_TIMEBASE};
  endproperty
  a_vec_val: assert property (p_vec_val) else $error("bad vector");
  property p_pulse;
    vector_load |=> !vector_load;
  endproperty
  a_pulse: assert property (p_pulse) else $error("vector load too long");
  property p_rec_len;
    $fell(sys_clk_enable) |=> !sys_clk_enable [*8];
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("clock gate too short");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer changed");
  c_load: cover property (vector_load);
  c_lv: cover property (ext_reset_pin_oe);
  c_gate: cover property ($fell(sys_clk_enable));
endmodule
bind stop_exit_low_voltage_reset lvr_chk u_chk (.core_clk, .rst_b, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .above_rising_threshold,
  .ext_reset_pin_out, .ext_reset_pin_oe, .device_reset, .sys_clk_enable, .wake_vector,
  .vector_load);
`default_nettype wire

/* File: stop_exit_low_voltage_reset_bench.sv */
// Self-checking bench for the stop exit and low voltage supervisor block
`timescale 1ns/10ps
`default_nettype none
`include "stop_lvs_defines.vh"
module stop_exit_low_voltage_reset_bench;
  logic core_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, por_event, timebase_rollover, rst_req, irq_req, kp_req, sr;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [1:0] lvl;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire ext_reset_pin_in, ext_reset_pin_out, ext_reset_pin_oe, ext_irq_pin;
  wire below_falling_threshold, above_rising_threshold;
  wire device_reset, sys_clk_enable, stop_active, wait_active, vector_load;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] wake_vector;
  wire [7:0] keypad_pins;
  int num_errors, cmp_count, seed, k, lo, cnt;
  logic [33:0] rsp_q[$];
  logic [15:0] vec_q[$];
  logic [15:0] vecs [4] = '{`VEC_EXT_IRQ, `VEC_KEYPAD, `VEC_TIMEBASE, `VEC_RESET};
  stop_exit_low_voltage_reset #(.REC_FULL_CNT(64), .REC_SHORT_CNT(32)) DUT (.core_clk,
    .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_reset_pin_in, .ext_irq_pin, .keypad_pins, .below_falling_threshold,
    .above_rising_threshold, .por_event, .timebase_rollover, .ext_reset_pin_out,
    .ext_reset_pin_oe, .device_reset, .sys_clk_enable, .stop_active, .wait_active,
    .wake_vector, .vector_load);
  pin_supply_model u_far (.lvl, .rst_req, .irq_req, .kp_req, .pin_out(ext_reset_pin_out),
    .pin_oe(ext_reset_pin_oe), .pin_in(ext_reset_pin_in), .irq_pin(ext_irq_pin),
    .kp_pins(keypad_pins), .below(below_falling_threshold), .above(above_rising_threshold));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    rsp_q.push_back({e, 32'h0});
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_bready) s_axi_bready <= 1'($random(seed));
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rsp_q.push_back(e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) s_axi_rready <= 1'($random(seed));
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask
  task automatic settle(input logic [1:0] l);
    lvl <= l;
    repeat (6) @(posedge core_clk);
  endtask
  // Results are paired with the oldest expectation as they appear
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, rsp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rsp_q.pop_front());
    if (vector_load) check(34'(wake_vector), 34'(vec_q.pop_front()));
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    seed = 32'ha38afe3e;
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {por_event, timebase_rollover, rst_req, irq_req, kp_req, lvl} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`ADDR_CONFIG_ONE, 34'h0);
    rd(4'h2, {`RESP_SLVERR, 32'h0});
    wr(`ADDR_LV_STATUS, 32'hffffffff, `RESP_OKAY);
    rd(`ADDR_LV_STATUS, 34'h0);
    for (k = 0; k < 4; k++) begin
      sr = 1'($random(seed));
      cnt = sr ? 32 : 64;
      wr(`ADDR_CONFIG_ONE, {31'h0, sr}, `RESP_OKAY);
      wr(`ADDR_MODE_CTRL, 32'h5, `RESP_OKAY);
      vec_q.push_back(vecs[k]);
      repeat (4) @(posedge core_clk);
      check(34'({stop_active, sys_clk_enable}), 34'h2);
      irq_req <= k == 0;
      kp_req <= k == 1;
      timebase_rollover <= k == 2;
      rst_req <= k == 3;
      @(posedge core_clk);
      timebase_rollover <= 1'b0;
      repeat (5) @(posedge core_clk);
      {irq_req, kp_req, rst_req} <= 3'h0;
      lo = 6;
      while (!sys_clk_enable && lo < 300) begin
        @(posedge core_clk);
        lo++;
      end
      check(34'(lo >= cnt && lo <= cnt + 16), 34'h1);
    end
    wr(`ADDR_MODE_CTRL, 32'h6, `RESP_OKAY);
    @(posedge core_clk);
    check(34'(wait_active), 34'h1);
    settle(2'h2);
    check(34'(device_reset), 34'h1);
    check(34'(ext_reset_pin_oe), 34'h1);
    check(34'(wait_active), 34'h0);
    rd(`ADDR_LV_STATUS, 34'h80);
    settle(2'h1);
    check(34'(device_reset), 34'h1);
    rd(`ADDR_LV_STATUS, 34'h80);
    settle(2'h0);
    check(34'(device_reset), 34'h0);
    rd(`ADDR_LV_STATUS, 34'h0);
    for (k = 2; k <= 4; k += 2) begin
      wr(`ADDR_CONFIG_ONE, 32'(k), `RESP_OKAY);
      settle(2'h2);
      check(34'(device_reset), 34'h0);
      rd(`ADDR_LV_STATUS, k == 4 ? 34'h80 : 34'h0);
      settle(2'h0);
    end
    wr(`ADDR_CONFIG_ONE, 32'h10, `RESP_OKAY);
    rd(`ADDR_CONFIG_ONE, 34'h10);
    por_event <= 1'b1;
    @(posedge core_clk);
    por_event <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(`ADDR_CONFIG_ONE, 34'h0);
    settle(2'h1);
    wr(`ADDR_CONFIG_ONE, 32'h10, `RESP_OKAY);
    settle(2'h1);
    check(34'(device_reset), 34'h1);
    settle(2'h0);
    check(34'(device_reset), 34'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
